// ===== design/brcl_top.sv
// Decided for this implementation: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/100ps

// ====================================================
// Reset pulse stretcher
module brcl_pulse #(
    parameter int LEN = 8
) (
    input  wire logic hclk,    // Board clock
    input  wire logic hresetn, // Async reset
    input  wire logic start,   // Start or restart pulse
    output logic      busy     // Pulse active
);
    localparam int W = $clog2(LEN + 1);

    logic [W-1:0] cnt;

    // Load on start, count down to zero
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cnt <= '0;
        else if (start)
            cnt <= W'(LEN);
        else if (cnt != '0)
            cnt <= cnt - 1'b1;
    end

    assign busy = (cnt != '0);
endmodule

module brcl_top #(
    parameter int POR_HOLD = brcl_pkg::POR_HOLD_CYC
) (
    input  wire logic        hclk,                  // Free-running clock
    input  wire logic        hresetn,               // Async reset
    input  wire logic        hsel,                  // Slave select
    input  wire logic [31:0] haddr,                 // Address
    input  wire logic [1:0]  htrans,                // Transfer type
    input  wire logic        hwrite,                // Write
    input  wire logic [2:0]  hsize,                 // Size, word only
    input  wire logic [31:0] hwdata,                // Write data
    input  wire logic        hready,                // Bus ready
    output logic             hreadyout,             // Slave ready
    output logic             hresp,                 // Response
    output logic [31:0]      hrdata,                // Read data
    input  wire logic        supply_ok,             // Supply good
    input  wire logic        clock_mode_sel,        // 1 = 1:5 mode
    input  wire logic        soft_reset_button_n,   // Soft button
    input  wire logic        abort_button_n,        // Abort button
    input  wire logic        board_access_valid,    // Board address hit
    input  wire logic        clk_gen_in,            // Clock generator
    input  wire logic        hard_reset_line_i,     // Line level
    output logic             hard_reset_line_o,     // Drive value
    output logic             hard_reset_line_oe,    // Pull low
    input  wire logic        soft_reset_line_i,     // Line level
    output logic             soft_reset_line_o,     // Drive value
    output logic             soft_reset_line_oe,    // Pull low
    output logic             power_on_reset_line_n, // Power-on reset
    output logic [1:0]       clock_mode_pins,       // Clock mode
    output logic             config_sample_strobe_n,// Config strobe
    output logic [15:0]      cfg_data_o,            // D0 at bit 15
    output logic             cfg_data_oe,           // Data drive
    output logic             xcvr_open,             // Transceiver open
    input  wire logic        external_irq_line0_i,  // Line level
    output logic             external_irq_line0_o,  // Drive value
    output logic             external_irq_line0_oe, // Pull low
    output logic             external_clock_input   // Gated clock
);

    // ====================================================
    // Declarations
    logic [31:0] por_cnt;
    logic        por_active;
    logic        mode_lat;
    logic        a_wr;
    logic [7:0]  a_ofs;
    logic [15:0] board_config_word_reg;
    logic [15:0] cfg_active;
    logic [15:0] next_cfg_active;
    logic        soft_prev;
    logic        hr_prev;
    logic        soft_busy;
    logic        hard_busy;

    wire addr_ok   = hsel & htrans[1] & hready;
    wire soft_prs  = ~soft_reset_button_n;
    wire abort_prs = ~abort_button_n;
    wire soft_edge = soft_prs & ~soft_prev;
    wire soft_evt  = soft_edge & ~abort_prs;
    wire hard_evt  = soft_edge & abort_prs;
    wire hr_act    = ~hard_reset_line_i | hard_reset_line_oe;
    wire sr_act    = ~soft_reset_line_i | soft_reset_line_oe;
    wire hr_rise   = hr_act & ~hr_prev;
    wire wr_cfg    = a_wr & (a_ofs == brcl_pkg::OFS_CFG);
    wire wr_ctrl   = a_wr & (a_ofs == brcl_pkg::OFS_CTRL);
    wire sw_hard   = wr_ctrl & hwdata[brcl_pkg::CTRL_SWHR];
    wire [31:0] stat_word;

    // ====================================================
    // Power-on reset supervisor
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            por_cnt <= '0;
        else if (!supply_ok)
            por_cnt <= '0;
        else if (por_active)
            por_cnt <= por_cnt + 32'h1;
    end

    assign por_active = (por_cnt < 32'(POR_HOLD));

    // Clock mode follows switch only during power-on
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            mode_lat <= 1'b1;
        else if (por_active)
            mode_lat <= clock_mode_sel;
    end

    // Power-on line and clock-mode pins
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            power_on_reset_line_n <= 1'b0;
            clock_mode_pins       <= brcl_pkg::MODE_1TO5;
        end
        else
        begin
            power_on_reset_line_n <= ~por_active;
            clock_mode_pins       <= mode_lat ? brcl_pkg::MODE_1TO5
                                              : brcl_pkg::MODE_1TO513;
        end
    end

    // Generator gated off in crystal mode
    assign external_clock_input = clk_gen_in & mode_lat;

    // ====================================================
    // Push-buttons and reset pulses
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            soft_prev <= 1'b0;
            hr_prev   <= 1'b0;
        end
        else
        begin
            soft_prev <= soft_prs;
            hr_prev   <= hr_act;
        end
    end

    brcl_pulse #(.LEN(brcl_pkg::RST_PULSE_CYC)) u_soft (
        .hclk    (hclk),
        .hresetn (hresetn),
        .start   (soft_evt),
        .busy    (soft_busy)
    );

    brcl_pulse #(.LEN(brcl_pkg::RST_PULSE_CYC)) u_hard (
        .hclk    (hclk),
        .hresetn (hresetn),
        .start   (hard_evt | sw_hard),
        .busy    (hard_busy)
    );

    // Open-drain drives: only ever pull low
    assign hard_reset_line_o    = 1'b0;
    assign soft_reset_line_o    = 1'b0;
    assign external_irq_line0_o = 1'b0;

    // Enables for reset and interrupt lines
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hard_reset_line_oe    <= 1'b1;
            soft_reset_line_oe    <= 1'b0;
            external_irq_line0_oe <= 1'b0;
        end
        else
        begin
            hard_reset_line_oe    <= por_active | hard_busy;
            soft_reset_line_oe    <= soft_busy;
            external_irq_line0_oe <= abort_prs & ~soft_prs;
        end
    end

    // ====================================================
    // Hard-reset configuration
    // Line may also be held by processor sources
    assign next_cfg_active = por_active ? brcl_pkg::CFG_DEFAULT
                           : hr_rise    ? board_config_word_reg
                           : cfg_active;

    // Software copy and word in effect
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            board_config_word_reg <= brcl_pkg::CFG_DEFAULT;
            cfg_active            <= brcl_pkg::CFG_DEFAULT;
        end
        else
        begin
            if (por_active)
                board_config_word_reg <= brcl_pkg::CFG_DEFAULT;
            else if (wr_cfg)
                board_config_word_reg <= hwdata[15:0];
            cfg_active <= next_cfg_active;
        end
    end

    // Strobe and data follow the sensed hard reset
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            config_sample_strobe_n <= 1'b1;
            cfg_data_o             <= brcl_pkg::CFG_DEFAULT;
            cfg_data_oe            <= 1'b0;
        end
        else
        begin
            config_sample_strobe_n <= ~hr_act;
            cfg_data_o             <= next_cfg_active;
            cfg_data_oe            <= hr_act;
        end
    end

    // Transceivers open for board or configuration
    assign xcvr_open = board_access_valid | ~config_sample_strobe_n;

    // ====================================================
    // AHB-Lite slave
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            a_wr  <= 1'b0;
            a_ofs <= 8'h00;
        end
        else if (hready)
        begin
            a_wr  <= addr_ok & hwrite;
            a_ofs <= haddr[7:0];
        end
    end

    // Status view of the block
    assign stat_word = {26'h0,
                        ~external_irq_line0_i,
                        mode_lat,
                        ~config_sample_strobe_n,
                        sr_act,
                        hr_act,
                        por_active};

    // Read mux, unmapped reads zero
    assign hrdata = (a_ofs == brcl_pkg::OFS_CFG)  ? {16'h0, board_config_word_reg}
                  : (a_ofs == brcl_pkg::OFS_ACT)  ? {16'h0, cfg_active}
                  : (a_ofs == brcl_pkg::OFS_STAT) ? stat_word
                  : 32'h0;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ====================================================
    // Checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_POR_HARD: assert property (
        por_active |=> hard_reset_line_oe)
        else $error("hard reset not held during power-on");

    AST_CFG_WORD: assert property (
        !config_sample_strobe_n |-> cfg_data_oe && cfg_data_o == cfg_active)
        else $error("config word not presented");

    AST_SOFT_BTN: assert property (
        soft_evt |=> ##1 soft_reset_line_oe [*8])
        else $error("soft button gave no soft reset");

    AST_HARD_BTN: assert property (
        hard_evt |=> ##1 (hard_reset_line_oe && !soft_reset_line_oe) [*8])
        else $error("button pair gave no hard reset");

    AST_OPEN_DRAIN: assert property (
        hard_reset_line_oe |-> hard_reset_line_o == 1'b0)
        else $error("reset line driven high");

    AST_MODE_11: assert property (
        por_active && mode_lat |=> clock_mode_pins == 2'h3)
        else $error("1:5 mode pins wrong");

    AST_MODE_00: assert property (
        por_active && !mode_lat |=> clock_mode_pins == 2'h0)
        else $error("1:513 mode pins wrong");

    AST_MODE_STABLE: assert property (
        $rose(power_on_reset_line_n) |-> $stable(clock_mode_pins))
        else $error("clock mode moved at power-on release");

    AST_DEFAULTS: assert property (
        $rose(power_on_reset_line_n) |->
        board_config_word_reg == brcl_pkg::CFG_DEFAULT)
        else $error("defaults not loaded at power-on");

    AST_STROBE: assert property (
        !hard_reset_line_i |=> !config_sample_strobe_n)
        else $error("strobe missing in hard reset");

    AST_RELEASE: assert property (
        $rose(config_sample_strobe_n) |-> !cfg_data_oe)
        else $error("config data held after strobe");

    AST_NMI: assert property (
        abort_prs && !soft_prs |=> external_irq_line0_oe)
        else $error("abort gave no interrupt");

    AST_GATE: assert property (
        !mode_lat |-> external_clock_input == 1'b0)
        else $error("clock input not held low");

    AST_XCVR: assert property (
        $fell(config_sample_strobe_n) |-> xcvr_open)
        else $error("transceivers closed during configuration");

endmodule

// ===== design/brcl_pkg.sv
package brcl_pkg;

    // ====================================================
    // Timing
    // Board control clock rate
    localparam int CLK_MHZ       = 125;
    // Power-on reset hold after supply good, least time
    localparam int POR_HOLD_NS   = 100000;
    localparam int POR_HOLD_CYC  = (POR_HOLD_NS * CLK_MHZ + 999) / 1000;
    // Push-button reset pulse, least time
    localparam int RST_PULSE_NS  = 8000;
    localparam int RST_PULSE_CYC = (RST_PULSE_NS * CLK_MHZ + 999) / 1000;

    // ====================================================
    // Register byte offsets
    localparam logic [7:0] OFS_CFG  = 8'h00;
    localparam logic [7:0] OFS_ACT  = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;
    localparam logic [7:0] OFS_CTRL = 8'h0C;

    // Control and status bit positions
    localparam int CTRL_SWHR = 0;
    localparam int ST_POR    = 0;
    localparam int ST_HARD   = 1;
    localparam int ST_SOFT   = 2;
    localparam int ST_STRB   = 3;
    localparam int ST_MODE   = 4;
    localparam int ST_NMI    = 5;

    // ====================================================
    // Configuration word fields, bit 15 carries D0
    localparam int ARB_POS  = 15;
    localparam int IPR_POS  = 14;
    localparam int BDIS_POS = 12;
    localparam int BPS_POS  = 10;
    localparam int ISB_POS  = 7;
    localparam int DBGC_POS = 5;
    localparam int DBPC_POS = 3;
    localparam int EBDF_POS = 1;

    // Field values of the power-on defaults
    localparam logic [15:0] ARB_INTERNAL = 16'h0000;
    localparam logic [15:0] IPR_ZERO     = 16'h0001;
    localparam logic [15:0] BOOT_ENABLE  = 16'h0000;
    localparam logic [15:0] BPS_32BIT    = 16'h0000;
    localparam logic [15:0] ISB_FF000000 = 16'h0003;
    localparam logic [15:0] DBGC_PCMCIAB = 16'h0000;
    localparam logic [15:0] DBPC_JTAG    = 16'h0002;
    localparam logic [15:0] EBDF_1TO1    = 16'h0000;

    localparam logic [15:0] CFG_DEFAULT =
        (ARB_INTERNAL << ARB_POS) | (IPR_ZERO << IPR_POS) |
        (BOOT_ENABLE << BDIS_POS) | (BPS_32BIT << BPS_POS) |
        (ISB_FF000000 << ISB_POS) | (DBGC_PCMCIAB << DBGC_POS) |
        (DBPC_JTAG << DBPC_POS) | (EBDF_1TO1 << EBDF_POS);

    // Clock-mode pin codes
    localparam logic [1:0] MODE_1TO5   = 2'h3;
    localparam logic [1:0] MODE_1TO513 = 2'h0;

endpackage

// ===== testbench/brcl_proc_model.sv
`timescale 1ns/100ps

// ====================================================
// Processor side: open-drain reset pulls and reset sampling
module brcl_proc_model #(
    parameter int INT_RST_CYC = 512
) (
    input  wire logic        hclk,                   // Board clock
    input  wire logic        power_on_reset_line_n,  // Power-on reset
    input  wire logic [1:0]  clock_mode_pins,        // Clock mode
    input  wire logic        config_sample_strobe_n, // Config strobe
    input  wire logic [15:0] cfg_data_o,             // Board data drive
    input  wire logic        cfg_data_oe,            // Board data enable
    input  wire logic        int_hard_req,           // Start internal reset
    output logic             hard_pull,              // Pull hard line low
    output logic             soft_pull,              // Pull soft line low
    output logic [1:0]       seen_mode,              // Sampled clock mode
    output logic [15:0]      seen_cfg,               // Sampled config
    input  wire logic        soft_reset_line,        // Resolved soft line
    input  wire logic        debug_serial_clock,     // Debug clock pin
    input  wire logic        debug_serial_input,     // Debug serial pin
    output logic [2:0]       seen_dbg                // Enable, entry, clock mode
);
    logic        soft_prev = 1'b0;
    logic [15:0] bus_last = 16'h0000;
    logic [15:0] data_bus;
    int          cnt = 0;

    // Released bus shows the inverse of its last value
    assign data_bus = cfg_data_oe ? cfg_data_o : ~bus_last;
    assign hard_pull = (cnt != 0);
    assign soft_pull = 1'b0;

    // Each reset level samples its own inputs
    always_ff @(posedge hclk)
    begin
        bus_last <= data_bus;
        if (!power_on_reset_line_n)
            seen_mode <= clock_mode_pins;
        if (!config_sample_strobe_n)
            seen_cfg <= data_bus;
    end

    // Soft level samples the debug port around release
    always_ff @(posedge hclk)
    begin
        soft_prev <= soft_reset_line;
        if (!soft_reset_line)
            seen_dbg[2] <= debug_serial_clock;
        else if (!soft_prev)
        begin
            seen_dbg[1] <= debug_serial_clock;
            seen_dbg[0] <= debug_serial_input;
        end
    end

    // Internal hard reset source, fixed length
    always_ff @(posedge hclk)
    begin
        if (int_hard_req && cnt == 0)
            cnt <= INT_RST_CYC;
        else if (cnt != 0)
            cnt <= cnt - 1;
    end
endmodule

// ===== testbench/tb_top.sv
`timescale 1ns/100ps

module tb_top;
    logic        hclk, hresetn, hsel, hwrite, supply_ok, mode_sel, clk_gen_in;
    logic        soft_btn_n, abort_btn_n, access_valid, int_req;
    logic [31:0] haddr, hwdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    wire         hreadyout, hresp, hard_o, hard_oe, soft_o, soft_oe, por_n, strobe_n;
    wire         data_oe, xcvr_open, irq_o, irq_oe, ext_clk, hard_pull, soft_pull;
    wire [31:0]  hrdata;
    wire [15:0]  cfg_data, seen_cfg;
    wire [1:0]   mode_pins, seen_mode;
    wire         hard_line, soft_line, irq_line;
    logic        debug_serial_clock, debug_serial_input;
    wire [2:0]   seen_dbg;
    int          err_total, num_checks, cyc;

    // ====================================================
    // Open-drain lines with pull-ups
    assign hard_line = ~(hard_oe | hard_pull);
    assign soft_line = ~(soft_oe | soft_pull);
    assign irq_line  = ~irq_oe;

    brcl_top #(.POR_HOLD(20)) DUT (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .supply_ok(supply_ok),
        .clock_mode_sel(mode_sel), .soft_reset_button_n(soft_btn_n),
        .abort_button_n(abort_btn_n), .board_access_valid(access_valid),
        .clk_gen_in(clk_gen_in), .hard_reset_line_i(hard_line),
        .hard_reset_line_o(hard_o), .hard_reset_line_oe(hard_oe),
        .soft_reset_line_i(soft_line), .soft_reset_line_o(soft_o),
        .soft_reset_line_oe(soft_oe), .power_on_reset_line_n(por_n),
        .clock_mode_pins(mode_pins), .config_sample_strobe_n(strobe_n),
        .cfg_data_o(cfg_data), .cfg_data_oe(data_oe), .xcvr_open(xcvr_open),
        .external_irq_line0_i(irq_line), .external_irq_line0_o(irq_o),
        .external_irq_line0_oe(irq_oe), .external_clock_input(ext_clk));

    brcl_proc_model PROC (
        .hclk(hclk), .power_on_reset_line_n(por_n), .clock_mode_pins(mode_pins),
        .config_sample_strobe_n(strobe_n), .cfg_data_o(cfg_data), .cfg_data_oe(data_oe),
        .int_hard_req(int_req), .hard_pull(hard_pull), .soft_pull(soft_pull),
        .seen_mode(seen_mode), .seen_cfg(seen_cfg), .soft_reset_line(soft_line),
        .debug_serial_clock(debug_serial_clock), .debug_serial_input(debug_serial_input),
        .seen_dbg(seen_dbg));

    // ====================================================
    // Clock, generator toggling and hang guard
    initial
    begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    always @(posedge hclk)
    begin
        clk_gen_in <= ~clk_gen_in;
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            $display("ERROR %0t timeout", $time);
            print_verdict();
        end
    end

    // ====================================================
    // Shared tasks
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task wait_cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask

    // Single word transfer, read data left in rd
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h000000, a};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    task print_verdict;
        if (err_total == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ====================================================
    // Scenarios
    task t_por(input logic sel, input logic [1:0] exp_mode);
        @(posedge hclk);
        hresetn <= 1'b0;
        supply_ok <= 1'b0;
        mode_sel <= sel;
        wait_cyc(4);
        hresetn <= 1'b1;
        wait_cyc(30);
        @(negedge hclk);
        chk(por_n, 1'b0);
        chk(hard_oe, 1'b1);
        chk(strobe_n, 1'b0);
        chk(data_oe, 1'b1);
        chk(xcvr_open, 1'b1);
        @(posedge hclk);
        supply_ok <= 1'b1;
        while (por_n !== 1'b1) @(posedge hclk);
        while (strobe_n !== 1'b1) @(posedge hclk);
        @(negedge hclk);
        chk(seen_mode, exp_mode);
        chk(mode_pins, exp_mode);
        chk(seen_cfg, 16'h4190);
        chk(data_oe, 1'b0);
        chk(xcvr_open, 1'b0);
        repeat (2)
        begin
            @(negedge hclk);
            chk(ext_clk, sel & clk_gen_in);
        end
    endtask

    task t_regs;
        ahb(1'b0, 8'h00, 32'h0); chk(rd, 32'h4190);
        ahb(1'b1, 8'h00, 32'h00002A5C);
        ahb(1'b0, 8'h00, 32'h0); chk(rd, 32'h2A5C);
        ahb(1'b1, 8'h04, 32'h0000FFFF);
        ahb(1'b0, 8'h04, 32'h0); chk(rd, 32'h4190);
        ahb(1'b0, 8'h10, 32'h0); chk(rd, 32'h0);
        ahb(1'b0, 8'h08, 32'h0); chk(rd, 32'h10);
        chk(hresp, 1'b0);
    endtask

    task t_soft;
        @(posedge hclk);
        soft_btn_n <= 1'b0;
        debug_serial_clock <= 1'b1;
        debug_serial_input <= 1'b0;
        wait_cyc(3);
        @(negedge hclk);
        chk(soft_oe, 1'b1);
        chk(hard_oe, 1'b0);
        chk(soft_line, 1'b0);
        chk({hard_o, soft_o, irq_o}, 3'h0);
        @(posedge hclk);
        soft_btn_n <= 1'b1;
        while (soft_oe !== 1'b0) @(posedge hclk);
        @(negedge hclk);
        chk(seen_dbg, 3'h6);
    endtask

    task t_hard;
        @(posedge hclk);
        abort_btn_n <= 1'b0;
        @(posedge hclk);
        soft_btn_n <= 1'b0;
        wait_cyc(3);
        @(negedge hclk);
        chk(hard_oe, 1'b1);
        chk(soft_oe, 1'b0);
        chk(strobe_n, 1'b0);
        @(posedge hclk);
        soft_btn_n <= 1'b1;
        abort_btn_n <= 1'b1;
        while (strobe_n !== 1'b1) @(posedge hclk);
        @(negedge hclk);
        chk(seen_cfg, 16'h2A5C);
        ahb(1'b0, 8'h04, 32'h0); chk(rd, 32'h2A5C);
    endtask

    task t_nmi;
        @(posedge hclk);
        abort_btn_n <= 1'b0;
        access_valid <= 1'b1;
        wait_cyc(2);
        @(negedge hclk);
        chk(irq_oe, 1'b1);
        chk(irq_line, 1'b0);
        chk(xcvr_open, 1'b1);
        @(posedge hclk);
        abort_btn_n <= 1'b1;
        access_valid <= 1'b0;
        wait_cyc(2);
        @(negedge hclk);
        chk(irq_oe, 1'b0);
    endtask

    task t_internal;
        ahb(1'b1, 8'h00, 32'h00001234);
        @(posedge hclk);
        int_req <= 1'b1;
        @(posedge hclk);
        int_req <= 1'b0;
        wait_cyc(3);
        @(negedge hclk);
        chk(hard_oe, 1'b0);
        chk(strobe_n, 1'b0);
        chk(data_oe, 1'b1);
        while (strobe_n !== 1'b1) @(posedge hclk);
        @(negedge hclk);
        chk(seen_cfg, 16'h1234);
        ahb(1'b0, 8'h04, 32'h0); chk(rd, 32'h1234);
    endtask

    task t_swhard;
        ahb(1'b1, 8'h00, 32'h0000C3A5);
        ahb(1'b1, 8'h0C, 32'h00000001);
        wait_cyc(2);
        @(negedge hclk);
        chk(hard_oe, 1'b1);
        chk(strobe_n, 1'b0);
        ahb(1'b0, 8'h08, 32'h0); chk(rd, 32'h1A);
        while (strobe_n !== 1'b1) @(posedge hclk);
        @(negedge hclk);
        chk(seen_cfg, 16'hC3A5);
    endtask

    // ====================================================
    // Main sequence
    initial
    begin
        {hresetn, hsel, hwrite, supply_ok, mode_sel, clk_gen_in, int_req} = 7'h00;
        {soft_btn_n, abort_btn_n, access_valid} = 3'h6;
        {haddr, hwdata, htrans, hsize} = {64'h0, 2'h0, 3'h2};
        {err_total, num_checks, cyc} = {32'd0, 32'd0, 32'd0};
        {debug_serial_clock, debug_serial_input} = 2'h0;
        t_por(1'b1, 2'h3);
        t_regs();
        t_soft();
        t_hard();
        t_nmi();
        t_internal();
        t_swhard();
        t_por(1'b0, 2'h0);
        ahb(1'b0, 8'h00, 32'h0); chk(rd, 32'h4190);
        print_verdict();
    end
endmodule
